// file: logic/dps_map.svh
// Constants of the command slot and write data port
`ifndef DPS_MAP_SVH
`define DPS_MAP_SVH

// ----------------------------------------------------------------------
// Slot framing
// ----------------------------------------------------------------------
`define DPS_SLOTS 4
`define DPS_BITS_PER_PIN 8
`define DPS_BITS_PER_SLOT 2
`define DPS_IDLE_BYTE 8'hFF

// ----------------------------------------------------------------------
// Timing in system clocks
// ----------------------------------------------------------------------
`define DPS_CMD_LATENCY 2
`define DPS_WR_LAT_PLAIN 1
`define DPS_WR_LAT_ECC 2

// ----------------------------------------------------------------------
// Command field positions inside the address pins
// ----------------------------------------------------------------------
`define DPS_RAS_PIN 16
`define DPS_CAS_PIN 15
`define DPS_WE_PIN 14

// ----------------------------------------------------------------------
// Pending write request counter
// ----------------------------------------------------------------------
`define DPS_PEND_W 4
`define DPS_PEND_MAX 4'hF

`endif

// file: logic/dps_pkg.sv
// Types shared by the command slot and write data port
package dps_pkg;

  typedef enum logic [0:0] {
    DPS_DDR3 = 1'b0,
    DPS_DDR4 = 1'b1
  } dps_dram_t;

  typedef enum logic [1:0] {
    DPS_MASK_OFF = 2'b00,
    DPS_MASK_WITHOUT_INVERSION_CFG = 2'b01,
    DPS_MASK_WITH_READ_INVERSION_CFG = 2'b10,
    DPS_INVERSION_ONLY = 2'b11
  } dps_mask_cfg_t;

endpackage

// file: logic/dps_slot_if.sv
// Bundle between the port and its slot unpacker
`timescale 1ns/1ns
interface dps_slot_if #(
  parameter int AW = 17,
  parameter int BW = 2,
  parameter int GW = 2,
  parameter int CW = 2
);
  logic [7:0] act_bytes;
  logic [8*AW-1:0] addr_bytes;
  logic [8*BW-1:0] bank_bytes;
  logic [8*GW-1:0] bg_bytes;
  logic [8*CW-1:0] cs_bytes;
  logic [3:0] act_slot;
  logic [4*AW-1:0] addr_slot;
  logic [4*BW-1:0] bank_slot;
  logic [4*GW-1:0] bg_slot;
  logic [4*CW-1:0] cs_slot;
  logic [2:0] wr_count;

  modport port (
    output act_bytes, addr_bytes, bank_bytes, bg_bytes, cs_bytes,
    input act_slot, addr_slot, bank_slot, bg_slot, cs_slot, wr_count
  );
  modport unpack (
    input act_bytes, addr_bytes, bank_bytes, bg_bytes, cs_bytes,
    output act_slot, addr_slot, bank_slot, bg_slot, cs_slot, wr_count
  );
endinterface

// file: logic/dps_slot_unpack.sv
// Splits pin bytes into per-slot values and counts write commands
`timescale 1ns/1ns
`include "dps_map.svh"
module dps_slot_unpack #(
  parameter int AW = 17,
  parameter int BW = 2,
  parameter int GW = 2,
  parameter int CW = 2
) (
  dps_slot_if.unpack sif
);

  // Slot s lives in bits 2s+1:2s; both bits match, so the lower one is taken
  function automatic logic [3:0] pin_slots(input logic [7:0] b);
    logic [3:0] r;
    r = 4'h0;
    for (int s = 0; s < `DPS_SLOTS; s++) begin
      r[s] = b[`DPS_BITS_PER_SLOT*s];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Per pin unpacking, byte p drives pin p
  // ----------------------------------------------------------------------
  assign sif.act_slot = pin_slots(sif.act_bytes); // R3

  genvar p, s;
  generate
    for (p = 0; p < AW; p++) begin : g_addr
      logic [3:0] t;
      assign t = pin_slots(sif.addr_bytes[8*p +: 8]); // R4
      for (s = 0; s < 4; s++) begin : g_s
        assign sif.addr_slot[s*AW+p] = t[s];
      end
    end
    for (p = 0; p < BW; p++) begin : g_bank
      logic [3:0] t;
      assign t = pin_slots(sif.bank_bytes[8*p +: 8]); // R4
      for (s = 0; s < 4; s++) begin : g_s
        assign sif.bank_slot[s*BW+p] = t[s];
      end
    end
    for (p = 0; p < GW; p++) begin : g_bg
      logic [3:0] t;
      assign t = pin_slots(sif.bg_bytes[8*p +: 8]); // R4
      for (s = 0; s < 4; s++) begin : g_s
        assign sif.bg_slot[s*GW+p] = t[s];
      end
    end
    for (p = 0; p < CW; p++) begin : g_cs
      logic [3:0] t;
      assign t = pin_slots(sif.cs_bytes[8*p +: 8]); // R4
      for (s = 0; s < 4; s++) begin : g_s
        assign sif.cs_slot[s*CW+p] = t[s];
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Write column commands: any rank selected, activate strobe high, RAS high, CAS low, WE low
  // ----------------------------------------------------------------------
  always_comb begin
    logic sel;
    logic [2:0] n;
    sel = 1'b0;
    n = 3'h0;
    for (int k = 0; k < `DPS_SLOTS; k++) begin
      sel = ~(&sif.cs_slot[k*CW +: CW]);
      if (sel && sif.act_slot[k] && sif.addr_slot[k*AW+`DPS_RAS_PIN] &&
          !sif.addr_slot[k*AW+`DPS_CAS_PIN] && !sif.addr_slot[k*AW+`DPS_WE_PIN]) begin // R1
        n = n + 3'h1;
      end
    end
    sif.wr_count = n;
  end

endmodule

// file: logic/dps_cmd_write_port.sv
// Command slot and write data port of a DRAM physical layer
//
// Behaviour
// (R1) Four independent command slots per system clock
// (R2) Controller keeps both bits of a slot equal
// (R3) Slot 0 in low bit pair, sent first
// (R4) Higher input byte drives higher DRAM pin
// (R5) Activate pattern in a slot issues Activate
// (R6) CS and CAS low in slot issues read
// (R7) All-high slot becomes no-operation or deselect
// (R8) One slot equals one DRAM clock, order kept
// (R9) Controller alone ensures DRAM protocol legality
// (R10) Eight bits per lane carry whole burst
// (R11) Data one cycle after request, two with ECC
// (R12) No write buffer; data taken only then
// (R13) One active-high mask bit per data byte
// (R14) Mask used only in masking configurations
// (R15) One request pulse per accepted write command; the backlog saturates at 15, so writes beyond it get no request
// (R16) All slot inputs sampled together, atomically
`timescale 1ns/1ns
`include "dps_map.svh"
module dps_cmd_write_port #(
  parameter int ADDR_WIDTH = 17,
  parameter int BANK_WIDTH = 2,
  parameter int BANK_GROUP_WIDTH = 2,
  parameter int CS_WIDTH = 2,
  parameter int DQ_WIDTH = 8,
  parameter dps_pkg::dps_dram_t DRAM_TYPE = dps_pkg::DPS_DDR4,
  parameter bit DDR3_MASK_EN = 1'b1,
  parameter dps_pkg::dps_mask_cfg_t DDR4_MASK_CFG = dps_pkg::DPS_MASK_WITHOUT_INVERSION_CFG,
  parameter bit ECC_EN = 1'b0
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic [7:0] SLOT_ACTIVATE_STROBE_N,
  input wire logic [ADDR_WIDTH*8-1:0] SLOT_ADDRESS_BITS,
  input wire logic [BANK_WIDTH*8-1:0] SLOT_BANK_BITS,
  input wire logic [BANK_GROUP_WIDTH*8-1:0] SLOT_BANK_GROUP_BITS,
  input wire logic [CS_WIDTH*8-1:0] SLOT_CHIP_SELECT_N,
  input wire logic [DQ_WIDTH*8-1:0] WRITE_BURST_DATA,
  input wire logic [DQ_WIDTH-1:0] WRITE_BYTE_MASK,
  output logic WRITE_DATA_REQUEST,
  output logic [3:0] DRAM_ACT_N,
  output logic [4*ADDR_WIDTH-1:0] DRAM_ADDR,
  output logic [4*BANK_WIDTH-1:0] DRAM_BANK,
  output logic [4*BANK_GROUP_WIDTH-1:0] DRAM_BANK_GROUP,
  output logic [4*CS_WIDTH-1:0] DRAM_CS_N,
  output logic DRAM_WR_VALID,
  output logic [DQ_WIDTH*8-1:0] DRAM_WR_DATA,
  output logic [DQ_WIDTH-1:0] DRAM_WR_MASK
);

  localparam int AW = ADDR_WIDTH;
  localparam int BW = BANK_WIDTH;
  localparam int GW = BANK_GROUP_WIDTH;
  localparam int CW = CS_WIDTH;
  localparam int DW = DQ_WIDTH * 8;

  // Mask pins carry data only in the configurations that have them
  function automatic bit mask_used(input dps_pkg::dps_dram_t t, input bit m3,
                                   input dps_pkg::dps_mask_cfg_t m4);
    if (t == dps_pkg::DPS_DDR3) begin
      return m3;
    end
    return (m4 == dps_pkg::DPS_MASK_WITHOUT_INVERSION_CFG) ||
           (m4 == dps_pkg::DPS_MASK_WITH_READ_INVERSION_CFG);
  endfunction

  localparam bit MASK_ON = mask_used(DRAM_TYPE, DDR3_MASK_EN, DDR4_MASK_CFG);

  typedef struct packed {
    logic [3:0] act;
    logic [4*AW-1:0] addr;
    logic [4*BW-1:0] bank;
    logic [4*GW-1:0] bg;
    logic [4*CW-1:0] cs;
  } dps_slots_t;

  typedef struct packed {
    dps_slots_t stage_a;
    dps_slots_t stage_b;
    logic [`DPS_PEND_W-1:0] pend;
    logic req;
    logic [1:0] req_pipe;
    logic wr_valid;
    logic [DW-1:0] wr_data;
    logic [DQ_WIDTH-1:0] wr_mask;
  } dps_state_t;

  dps_state_t st_r;
  dps_state_t st_nxt;

  dps_slot_if #(.AW(AW), .BW(BW), .GW(GW), .CW(CW)) sif ();

  // ----------------------------------------------------------------------
  // Slot unpacking
  // ----------------------------------------------------------------------
  assign sif.act_bytes = SLOT_ACTIVATE_STROBE_N;
  assign sif.addr_bytes = SLOT_ADDRESS_BITS;
  assign sif.bank_bytes = SLOT_BANK_BITS;
  assign sif.bg_bytes = SLOT_BANK_GROUP_BITS;
  assign sif.cs_bytes = SLOT_CHIP_SELECT_N;

  dps_slot_unpack #(.AW(AW), .BW(BW), .GW(GW), .CW(CW)) u_unpack (
    .sif(sif.unpack)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [`DPS_PEND_W:0] total;
    logic capture;
    total = '0;
    capture = 1'b0;
    st_nxt = st_r;

    // Whole cycle captured on one edge, then one more stage to the pins
    st_nxt.stage_a.act = sif.act_slot; // R16
    st_nxt.stage_a.addr = sif.addr_slot; // R16
    st_nxt.stage_a.bank = sif.bank_slot;
    st_nxt.stage_a.bg = sif.bg_slot;
    st_nxt.stage_a.cs = sif.cs_slot;
    // Slots pass unchanged, so activates, reads and idle slots keep position
    st_nxt.stage_b = st_r.stage_a; // R5 R6 R7 R8

    // Writes from one cycle may number up to four; requests go out one per cycle
    total = {1'b0, st_r.pend} + {{(`DPS_PEND_W-2){1'b0}}, sif.wr_count};
    st_nxt.req = (total != '0); // R15
    if (total == '0) begin
      st_nxt.pend = '0;
    end else if (total - 1'b1 > {1'b0, `DPS_PEND_MAX}) begin
      st_nxt.pend = `DPS_PEND_MAX;
    end else begin
      st_nxt.pend = total[`DPS_PEND_W-1:0] - 1'b1; // R15
    end

    st_nxt.req_pipe = {st_r.req_pipe[0], st_r.req};
    capture = ECC_EN ? st_r.req_pipe[1] : st_r.req_pipe[0]; // R11
    st_nxt.wr_valid = capture; // R12
    if (capture) begin
      st_nxt.wr_data = WRITE_BURST_DATA; // R10
      st_nxt.wr_mask = MASK_ON ? WRITE_BYTE_MASK : '0; // R13 R14
    end
  end

  // ----------------------------------------------------------------------
  // State register; idle slots after reset are all high
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_r.stage_a <= '1;
      st_r.stage_b <= '1;
      st_r.pend <= '0;
      st_r.req <= 1'b0;
      st_r.req_pipe <= 2'h0;
      st_r.wr_valid <= 1'b0;
      st_r.wr_data <= '0;
      st_r.wr_mask <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign WRITE_DATA_REQUEST = st_r.req; // R15
  assign DRAM_ACT_N = st_r.stage_b.act;
  assign DRAM_ADDR = st_r.stage_b.addr;
  assign DRAM_BANK = st_r.stage_b.bank;
  assign DRAM_BANK_GROUP = st_r.stage_b.bg;
  assign DRAM_CS_N = st_r.stage_b.cs;
  assign DRAM_WR_VALID = st_r.wr_valid;
  assign DRAM_WR_DATA = st_r.wr_data;
  assign DRAM_WR_MASK = st_r.wr_mask;

endmodule

// file: tb/dps_cmd_write_port_sva.sv
// Assertions on the ports of the command slot and write data port
`timescale 1ns/1ns
module dps_cmd_write_port_sva #(
  parameter int AW = 17,
  parameter int BW = 2,
  parameter int GW = 2,
  parameter int CW = 2,
  parameter int DW = 8
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic [7:0] SLOT_ACTIVATE_STROBE_N,
  input wire logic [AW*8-1:0] SLOT_ADDRESS_BITS,
  input wire logic [BW*8-1:0] SLOT_BANK_BITS,
  input wire logic [GW*8-1:0] SLOT_BANK_GROUP_BITS,
  input wire logic [CW*8-1:0] SLOT_CHIP_SELECT_N,
  input wire logic [DW*8-1:0] WRITE_BURST_DATA,
  input wire logic [DW-1:0] WRITE_BYTE_MASK,
  input wire logic WRITE_DATA_REQUEST,
  input wire logic [3:0] DRAM_ACT_N,
  input wire logic [4*AW-1:0] DRAM_ADDR,
  input wire logic [4*BW-1:0] DRAM_BANK,
  input wire logic [4*GW-1:0] DRAM_BANK_GROUP,
  input wire logic [4*CW-1:0] DRAM_CS_N,
  input wire logic DRAM_WR_VALID,
  input wire logic [DW*8-1:0] DRAM_WR_DATA,
  input wire logic [DW-1:0] DRAM_WR_MASK
);
  logic [1:0] up_r;
  logic [2:0] wc;
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // Two-cycle lookbacks are only trusted once two edges have passed since reset
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      up_r <= 2'h0;
    end else if (up_r != 2'h3) begin
      up_r <= up_r + 2'h1;
    end
  end
  always_comb begin
    logic sel;
    sel = 1'b0;
    wc = 3'h0;
    for (int s = 0; s < 4; s++) begin
      sel = 1'b0;
      for (int r = 0; r < CW; r++) begin
        sel = sel | ~SLOT_CHIP_SELECT_N[8*r+2*s];
      end
      if (sel && SLOT_ACTIVATE_STROBE_N[2*s] && SLOT_ADDRESS_BITS[128+2*s] && !SLOT_ADDRESS_BITS[120+2*s]
          && !SLOT_ADDRESS_BITS[112+2*s]) begin
        wc = wc + 3'h1;
      end
    end
  end
  function automatic logic [135:0] unpk(input logic [135:0] b, input int n);
    unpk = '0;
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < n; p++) begin
        unpk[s*n+p] = b[8*p+2*s];
      end
    end
  endfunction
  a_act_slot_map: assert property (
    up_r[1] |-> 136'(DRAM_ACT_N) == unpk(136'($past(SLOT_ACTIVATE_STROBE_N, 2)), 1)) else $error("act slots");
  a_cs_rank_map: assert property (
    up_r[1] |-> 136'(DRAM_CS_N) == unpk(136'($past(SLOT_CHIP_SELECT_N, 2)), CW)) else $error("cs slots");
  a_addr_pin_map: assert property (
    up_r[1] |-> 136'(DRAM_ADDR) == unpk(136'($past(SLOT_ADDRESS_BITS, 2)), AW)) else $error("addr slots");
  a_bank_pin_map: assert property (
    up_r[1] |-> 136'(DRAM_BANK) == unpk(136'($past(SLOT_BANK_BITS, 2)), BW)
    && 136'(DRAM_BANK_GROUP) == unpk(136'($past(SLOT_BANK_GROUP_BITS, 2)), GW)) else $error("bank slots");
  a_req_one_write: assert property (
    (!WRITE_DATA_REQUEST && wc == 3'h1) |=> WRITE_DATA_REQUEST) else $error("request missing");
  a_req_no_write: assert property (
    (!WRITE_DATA_REQUEST && wc == 3'h0) |=> !WRITE_DATA_REQUEST) else $error("stray request");
  a_valid_after_req: assert property (
    up_r[1] |-> DRAM_WR_VALID == $past(WRITE_DATA_REQUEST, 2)) else $error("capture cycle");
  a_data_capture: assert property (
    DRAM_WR_VALID |-> DRAM_WR_DATA == $past(WRITE_BURST_DATA) && DRAM_WR_MASK == $past(WRITE_BYTE_MASK))
    else $error("captured data");
endmodule
bind dps_cmd_write_port dps_cmd_write_port_sva #(.AW(ADDR_WIDTH), .BW(BANK_WIDTH), .GW(BANK_GROUP_WIDTH),
  .CW(CS_WIDTH), .DW(DQ_WIDTH)) u_sva (.MCLK(MCLK), .SYS_RST(SYS_RST),
  .SLOT_ACTIVATE_STROBE_N(SLOT_ACTIVATE_STROBE_N), .SLOT_ADDRESS_BITS(SLOT_ADDRESS_BITS),
  .SLOT_BANK_BITS(SLOT_BANK_BITS), .SLOT_BANK_GROUP_BITS(SLOT_BANK_GROUP_BITS),
  .SLOT_CHIP_SELECT_N(SLOT_CHIP_SELECT_N), .WRITE_BURST_DATA(WRITE_BURST_DATA), .WRITE_BYTE_MASK(WRITE_BYTE_MASK),
  .WRITE_DATA_REQUEST(WRITE_DATA_REQUEST), .DRAM_ACT_N(DRAM_ACT_N), .DRAM_ADDR(DRAM_ADDR), .DRAM_BANK(DRAM_BANK),
  .DRAM_BANK_GROUP(DRAM_BANK_GROUP), .DRAM_CS_N(DRAM_CS_N), .DRAM_WR_VALID(DRAM_WR_VALID),
  .DRAM_WR_DATA(DRAM_WR_DATA), .DRAM_WR_MASK(DRAM_WR_MASK));

// file: tb/dps_ctrl_model.sv
// User controller model that supplies a write burst per request
`timescale 1ns/1ns
module dps_ctrl_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  output logic [63:0] data = '0,
  output logic [7:0] mask = '0
);
  logic due = 1'b0;
  // Outside the one legal cycle the lines toggle, so a capture in the wrong cycle shows
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      due <= 1'b0;
      data <= '0;
      mask <= '0;
    end else begin
      due <= req;
      if (due) begin
        data <= {$urandom, $urandom};
        mask <= 8'($urandom);
      end else begin
        data <= ~data;
        mask <= ~mask;
      end
    end
  end
endmodule

// file: tb/dps_cmd_write_port_tb_top.sv
// Self-checking testbench of the command slot and write data port
`timescale 1ns/1ns
module dps_cmd_write_port_tb_top;
  logic mclk = 1'b0, sys_rst = 1'b1, req, wv, xr, r1, xv;
  logic [7:0] act_n = '1, o_ba, o_bg, o_cs, wm, o_wm, xm;
  logic [135:0] adr = '1;
  logic [15:0] ba = '1, bg = '1, cs_n = '1;
  logic [3:0] o_act;
  logic [67:0] o_adr;
  logic [63:0] wd, o_wd, xd;
  logic [95:0] p1, p2;
  int errors = 0, num_checks = 0, cyc = 0, pend = 0;
  always #50 mclk = ~mclk;
  dps_cmd_write_port u_dps_cmd_write_port (.MCLK(mclk), .SYS_RST(sys_rst), .SLOT_ACTIVATE_STROBE_N(act_n),
    .SLOT_ADDRESS_BITS(adr), .SLOT_BANK_BITS(ba), .SLOT_BANK_GROUP_BITS(bg), .SLOT_CHIP_SELECT_N(cs_n),
    .WRITE_BURST_DATA(wd), .WRITE_BYTE_MASK(wm), .WRITE_DATA_REQUEST(req), .DRAM_ACT_N(o_act), .DRAM_ADDR(o_adr),
    .DRAM_BANK(o_ba), .DRAM_BANK_GROUP(o_bg), .DRAM_CS_N(o_cs), .DRAM_WR_VALID(wv), .DRAM_WR_DATA(o_wd),
    .DRAM_WR_MASK(o_wm));
  dps_ctrl_model u_dps_ctrl_model (.clk(mclk), .rst(sys_rst), .req(req), .data(wd), .mask(wm));
  function automatic logic [7:0] dup(input logic [3:0] n);
    for (int s = 0; s < 4; s++) begin
      dup[2*s+:2] = {2{n[s]}};
    end
  endfunction
  function automatic logic [95:0] slots();
    logic [95:0] e;
    for (int s = 0; s < 4; s++) begin
      e[92+s] = act_n[2*s];
      for (int p = 0; p < 17; p++) begin
        e[24+s*17+p] = adr[8*p+2*s];
      end
      for (int p = 0; p < 2; p++) begin
        e[16+s*2+p] = ba[8*p+2*s];
        e[8+s*2+p] = bg[8*p+2*s];
        e[s*2+p] = cs_n[8*p+2*s];
      end
    end
    return e;
  endfunction
  function automatic int wcnt();
    int n = 0;
    for (int s = 0; s < 4; s++) begin
      n += int'((!cs_n[2*s] || !cs_n[8+2*s]) && act_n[2*s] && adr[128+2*s] && !adr[120+2*s] && !adr[112+2*s]);
    end
    return n;
  endfunction
  task automatic check(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Slot command per two bits: 0 idle, 1 activate, 2 read, 3 write; rk picks rank 1
  task automatic put(input logic [7:0] c, input logic [3:0] rk);
    logic [3:0] a = '1, c0 = '1, c1 = '1, ca = '1, we = '1;
    @(negedge mclk);
    for (int s = 0; s < 4; s++) begin
      a[s] = c[2*s+:2] != 2'h1;
      ca[s] = c[2*s+:2] < 2'h2;
      we[s] = c[2*s+:2] != 2'h3;
      c0[s] = c[2*s+:2] == 2'h0 || rk[s];
      c1[s] = c[2*s+:2] == 2'h0 || !rk[s];
    end
    for (int p = 0; p < 14; p++) begin
      adr[8*p+:8] = dup(4'($urandom));
    end
    adr[135:112] = {8'hFF, dup(ca), dup(we)};
    ba = {dup(4'($urandom)), dup(4'($urandom))};
    bg = {dup(4'($urandom)), dup(4'($urandom))};
    act_n = dup(a);
    cs_n = {dup(c1), dup(c0)};
  endtask
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      {p1, p2, xr, r1, xv, xd, xm} <= {{192{1'b1}}, 75'h0};
      pend = 0;
    end else begin
      p1 <= slots();
      p2 <= p1;
      pend = pend + wcnt();
      xr <= pend > 0;
      pend = pend - int'(pend > 0);
      // Backlog of outstanding requests tops out at fifteen
      if (pend > 15) pend = 15;
      r1 <= xr;
      xv <= r1;
      if (r1) begin
        xd <= wd;
        xm <= wm;
      end
    end
  end
  always @(negedge mclk) begin
    if (!sys_rst) begin
      check({o_act, o_adr, o_ba, o_bg, o_cs} === p2, "slot outputs");
      check(req === xr, "write request");
      check(wv === xv && o_wd === xd && o_wm === xm, "write data");
    end
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 2000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(37));
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    sys_rst <= 1'b0;
    put(8'h04, 4'h0);
    put(8'h00, 4'h0);
    put(8'h00, 4'h0);
    put(8'h02, 4'h0);
    @(negedge mclk);
    {act_n, adr[135:112], ba, bg, cs_n} = {8'hF3, 24'h0F3CCF, 48'h0C3C_300C_3FC0};
    put(8'h00, 4'h0);
    @(negedge mclk);
    check(o_ba === 8'h1C && o_bg === 8'h24 && o_act === 4'hD && o_cs === 8'h6A, "four slots");
    put(8'hFF, 4'h5);
    put(8'hFF, 4'hA);
    repeat (4) put(8'hFF, 4'h3);
    repeat (10) put(8'h00, 4'h0);
    repeat (10) put(8'h00, 4'h0);
    for (int i = 0; i < 300; i++) begin
      put(8'($urandom) & 8'($urandom), 4'($urandom));
      if (i == 150) begin
        @(negedge mclk);
        {act_n, cs_n, sys_rst} <= {24'hFF_FFFF, 1'b1};
        repeat (2) @(negedge mclk);
        sys_rst <= 1'b0;
      end
    end
    repeat (6) put(8'h00, 4'h0);
    stop_test();
  end
endmodule
